/* File: rtl/ppd_decode.sv */
// mode dependent register decode for an ieee1284 parallel port
//
// Behaviour
// - compatibility, bidir, fifo, epp, ecp modes supported
// - 21 runtime registers share 14 offsets
// - mode taken from extended mode control
// - mode picks responders and base compare bits
// - offsets 403h-405h serve extended trio in every mode
// - four second level registers via index/data
// - extended trio reachable only when setup bit4
// - activate reg 30h resets 00h, global bit0
// - base high resets 02h, bits 7-3 zero
// - base low resets 78h, bits 1-0 zero
// - irq select at 70h resets 07h
// - irq type 71h resets 02h, bit1 writable
// - irq type bit0 is one in cfg mode 7
// - 75h reads 04h, dma select resets 04h
// - extended trio ignored when access disabled
// - setup mode 111 runs ecp, allows epp
`timescale 1ns/10ps
`include "ppd_cfg.svh"
module ppd_decode
  import ppd_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic global_enable_i,
  input wire logic [15:0] io_addr_i,
  input wire logic [7:0] port_status_i,
  input wire logic [7:0] queue_rdata_i,
  output logic [2:0] mode_o,
  output logic port_active_o,
  output logic io_hit_o,
  output logic [4:0] reg_sel_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [7:0] reg_wdata_o
);
  // register selection codes reported to the port engine
  localparam logic [4:0] SEL_NONE = 5'h00;
  localparam logic [4:0] SEL_SPP = 5'h01;
  localparam logic [4:0] SEL_AQ = 5'h02;
  localparam logic [4:0] SEL_EPPD = 5'h03;
  localparam logic [4:0] SEL_STAT = 5'h04;
  localparam logic [4:0] SEL_ESTAT = 5'h05;
  localparam logic [4:0] SEL_CTRL = 5'h06;
  localparam logic [4:0] SEL_ECTRL = 5'h07;
  localparam logic [4:0] SEL_EADR = 5'h08;
  localparam logic [4:0] SEL_LANE = 5'h09;
  localparam logic [4:0] SEL_OQ = 5'h0D;
  localparam logic [4:0] SEL_DQ = 5'h0E;
  localparam logic [4:0] SEL_TQ = 5'h0F;
  localparam logic [4:0] SEL_CAPA = 5'h10;
  localparam logic [4:0] SEL_CAPB = 5'h11;
  localparam logic [4:0] SEL_EMC = 5'h12;
  localparam logic [4:0] SEL_EIDX = 5'h13;
  localparam logic [4:0] SEL_EDAT = 5'h14;
  localparam logic [4:0] SEL_EAUX = 5'h15;
  localparam logic [7:0] CAP_A_VAL = 8'h10;
  localparam logic [7:0] CAP_B_VAL = 8'h00;

  ppd_state_type state_q;
  logic [7:0] act_q, bhi_q, blo_q, irq_q, ityp_q, dma_q, setup_q, emc_q;
  logic [7:0] eidx_q, eaux_q, ctrl_q, eadr_q, spp_q;
  logic [7:0] rd_q;
  logic [2:0] mode_q;
  logic act_out_q, hit_q, wr_q, rd_pulse_q;
  logic [4:0] sel_q;
  logic [7:0] wdata_q;
  logic [7:0] slot_rdata;
  logic slot_we;
  logic [7:0] wb;
  logic [10:0] rt_idx;
  logic is_cfg, req, wr_ok;
  logic [4:0] sel_now;
  ppd_mode_type mode;
  logic xen;

  ////////////////////////////////////////////////////////////////////
  // decode helpers

  // runtime offset to register per mode, used for the bus path only
  function automatic logic [4:0] rt_select(input logic [10:0] idx, input ppd_mode_type m,
                                           input logic x);
    logic [4:0] s;
    s = SEL_NONE;
    case (idx)
      `PPD_RT_DATA: begin
        case (m)
          PPD_M_SPP, PPD_M_PS2: s = SEL_SPP;
          PPD_M_ECP: s = SEL_AQ;
          PPD_M_EPP: s = SEL_EPPD;
          default: s = SEL_NONE;
        endcase
      end
      `PPD_RT_STAT: s = (m == PPD_M_EPP) ? SEL_ESTAT : (m <= PPD_M_ECP) ? SEL_STAT : SEL_NONE;
      `PPD_RT_CTRL: s = (m == PPD_M_EPP) ? SEL_ECTRL : (m <= PPD_M_ECP) ? SEL_CTRL : SEL_NONE;
      `PPD_RT_QUEUE: begin
        case (m)
          PPD_M_PPQ: s = SEL_OQ;
          PPD_M_ECP: s = SEL_DQ;
          PPD_M_TST: s = SEL_TQ;
          PPD_M_CFG: s = SEL_CAPA;
          default: s = SEL_NONE;
        endcase
      end
      `PPD_RT_CAPB: s = (m == PPD_M_CFG) ? SEL_CAPB : SEL_NONE;
      `PPD_RT_EMC: s = SEL_EMC;
      `PPD_RT_EIDX: s = x ? SEL_EIDX : SEL_NONE;
      `PPD_RT_EDAT: s = x ? SEL_EDAT : SEL_NONE;
      `PPD_RT_EAUX: s = x ? SEL_EAUX : SEL_NONE;
      default: begin
        if (m == PPD_M_EPP && idx == `PPD_RT_EADR) begin
          s = SEL_EADR;
        end else if (m == PPD_M_EPP && idx >= `PPD_RT_LANE0 && idx <= `PPD_RT_LANE3) begin
          s = SEL_LANE + 5'(idx[1:0]);
        end else begin
          s = SEL_NONE;
        end
      end
    endcase
    return s;
  endfunction

  // second level index is one of the four implemented slots
  function automatic logic slot_valid(input logic [7:0] ix);
    return ix[7:3] == 5'h00 && (ix[2:0] == `PPD_SL_C0 || ix[2:0] == `PPD_SL_C2 ||
                                ix[2:0] == `PPD_SL_C4 || ix[2:0] == `PPD_SL_S0);
  endfunction

  ////////////////////////////////////////////////////////////////////
  // request decode

  // config bank aliases: only the low 8 bits of the index are decoded
  assign is_cfg = avs_address_i >= `PPD_CFG_BASE;
  assign rt_idx = avs_address_i[10:0];
  assign req = (avs_read_i || avs_write_i) && state_q == PPD_S_IDLE;
  assign wr_ok = req && avs_write_i && avs_byteenable_i[0];
  assign wb = avs_writedata_i[7:0];
  // setup mode 111 lets the ecp control field choose epp
  assign mode = (setup_q[`PPD_EMC_MODE_HI:`PPD_EMC_MODE_LO] == 3'b111 ||
                 emc_q[`PPD_EMC_MODE_HI:`PPD_EMC_MODE_LO] != 3'h4) ?
                ppd_mode_type'(emc_q[`PPD_EMC_MODE_HI:`PPD_EMC_MODE_LO]) : PPD_M_PS2;
  assign xen = setup_q[`PPD_SETUP_XEN];
  assign sel_now = is_cfg ? SEL_NONE : rt_select(rt_idx, mode, xen);
  assign slot_we = wr_ok && sel_now == SEL_EDAT && slot_valid(eidx_q);

  // read address follows the index, so slot data are ready one cycle after take
  ppd_slot_mem u_slots (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .we_i(slot_we),
    .waddr_i(eidx_q[`PPD_SLOT_BITS-1:0]),
    .wdata_i(wb),
    .raddr_i(eidx_q[`PPD_SLOT_BITS-1:0]),
    .rdata_o(slot_rdata)
  );

  ////////////////////////////////////////////////////////////////////
  // bus handshake: two wait cycles, answer on the second edge

  // requests seen in ans or done are left waiting; the master keeps them up
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      state_q <= PPD_S_IDLE;
    end else begin
      case (state_q)
        PPD_S_IDLE: state_q <= req ? PPD_S_ANS : PPD_S_IDLE;
        PPD_S_ANS: state_q <= PPD_S_DONE;
        PPD_S_DONE: state_q <= PPD_S_IDLE;
        default: state_q <= PPD_S_IDLE;
      endcase
    end
  end

  // waitrequest low only in the done cycle, one cycle after ans
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      // registered, so the answer never follows the request combinationally
      avs_waitrequest_o <= (state_q == PPD_S_ANS) ? 1'b0 : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // configuration bank writes

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      act_q <= `PPD_RST_ACT;
      bhi_q <= `PPD_RST_BHI;
      blo_q <= `PPD_RST_BLO;
      irq_q <= `PPD_RST_IRQ;
      ityp_q <= `PPD_RST_ITYP;
      dma_q <= `PPD_RST_DMA;
      setup_q <= `PPD_RST_SETUP;
    end else if (wr_ok && is_cfg) begin
      case (avs_address_i[7:0])
        `PPD_CX_ACT: act_q <= wb;
        `PPD_CX_BHI: bhi_q <= wb & `PPD_BHI_MASK;
        `PPD_CX_BLO: blo_q <= wb & `PPD_BLO_MASK;
        `PPD_CX_IRQ: irq_q <= wb;
        `PPD_CX_ITYP: ityp_q[`PPD_ITYP_WR] <= wb[`PPD_ITYP_WR];
        `PPD_CX_DMA: dma_q <= wb;
        `PPD_CX_SETUP: setup_q <= wb;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // runtime registers kept locally
  // only the low byte lane is honoured; other byte enables are ignored

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      emc_q <= `PPD_RST_EMC;
      eidx_q <= 8'h00;
      eaux_q <= 8'h00;
      ctrl_q <= 8'h00;
      eadr_q <= 8'h00;
      spp_q <= 8'h00;
    end else if (wr_ok) begin
      case (sel_now)
        SEL_EMC: emc_q <= wb;
        SEL_EIDX: eidx_q <= wb;
        SEL_EAUX: eaux_q <= wb;
        SEL_CTRL, SEL_ECTRL: ctrl_q <= wb;
        SEL_EADR: eadr_q <= wb;
        SEL_SPP, SEL_EPPD: spp_q <= wb;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // read data, captured at the request edge

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      rd_q <= 8'h00;
    end else if (req && avs_read_i) begin
      if (is_cfg) begin
        case (avs_address_i[7:0])
          `PPD_CX_ACT: rd_q <= act_q;
          `PPD_CX_BHI: rd_q <= bhi_q;
          `PPD_CX_BLO: rd_q <= blo_q;
          `PPD_CX_IRQ: rd_q <= irq_q;
          `PPD_CX_ITYP: rd_q <= {ityp_q[7:1], mode == PPD_M_CFG};
          `PPD_CX_DMA: rd_q <= dma_q;
          `PPD_CX_DMA2: rd_q <= `PPD_VAL_DMA2;
          `PPD_CX_SETUP: rd_q <= setup_q;
          default: rd_q <= 8'h00;
        endcase
      end else begin
        case (sel_now)
          SEL_SPP, SEL_EPPD: rd_q <= spp_q;
          SEL_STAT, SEL_ESTAT: rd_q <= port_status_i;
          SEL_CTRL, SEL_ECTRL: rd_q <= ctrl_q;
          SEL_EADR: rd_q <= eadr_q;
          SEL_DQ, SEL_TQ: rd_q <= queue_rdata_i;
          SEL_CAPA: rd_q <= CAP_A_VAL;
          SEL_CAPB: rd_q <= CAP_B_VAL;
          SEL_EMC: rd_q <= emc_q;
          SEL_EIDX: rd_q <= eidx_q;
          SEL_EAUX: rd_q <= eaux_q;
          default: rd_q <= 8'h00;
        endcase
      end
    end
  end

  // data window reads come from the registered slot port one cycle later
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (state_q == PPD_S_ANS) begin
      avs_readdata_o <= {24'h00_0000, (sel_q == SEL_EDAT && slot_valid(eidx_q)) ?
                         slot_rdata : rd_q};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // strobes to the port engine
  // strobes only for decoded runtime registers, config accesses stay local

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      sel_q <= SEL_NONE;
      wr_q <= 1'b0;
      rd_pulse_q <= 1'b0;
      wdata_q <= 8'h00;
    end else begin
      wr_q <= wr_ok && !is_cfg && sel_now != SEL_NONE;
      rd_pulse_q <= req && avs_read_i && !is_cfg && sel_now != SEL_NONE;
      if (req) begin
        sel_q <= sel_now;
        wdata_q <= wb;
      end
    end
  end
  assign reg_sel_o = sel_q;
  assign reg_wr_o = wr_q;
  assign reg_rd_o = rd_pulse_q;
  assign reg_wdata_o = wdata_q;

  ////////////////////////////////////////////////////////////////////
  // activity, mode and io base match

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      act_out_q <= 1'b0;
      mode_q <= 3'h0;
      hit_q <= 1'b0;
    end else begin
      act_out_q <= act_q[0] && global_enable_i;
      mode_q <= mode;
      // epp and extended use need an 8 byte block, else 4
      // high byte bit 2 is compared too, a set value moves the block up 1k
      if (mode == PPD_M_EPP || xen) begin
        hit_q <= act_q[0] && global_enable_i &&
                 io_addr_i[15:3] == {bhi_q, blo_q[7:3]} && !io_addr_i[10] == !bhi_q[2];
      end else begin
        hit_q <= act_q[0] && global_enable_i && io_addr_i[15:2] == {bhi_q, blo_q[7:2]};
      end
    end
  end
  assign mode_o = mode_q;
  assign port_active_o = act_out_q;
  assign io_hit_o = hit_q;
endmodule // ppd_decode

/* File: rtl/ppd_cfg.svh */
// constants for the parallel port register decode block
`ifndef PPD_CFG_SVH
`define PPD_CFG_SVH
// avalon word indexes (byte address = index * 4), runtime space
`define PPD_RT_DATA 11'h000
`define PPD_RT_STAT 11'h001
`define PPD_RT_CTRL 11'h002
`define PPD_RT_EADR 11'h003
`define PPD_RT_LANE0 11'h004
`define PPD_RT_LANE3 11'h007
`define PPD_RT_QUEUE 11'h400
`define PPD_RT_CAPB 11'h401
`define PPD_RT_EMC 11'h402
`define PPD_RT_EIDX 11'h403
`define PPD_RT_EDAT 11'h404
`define PPD_RT_EAUX 11'h405
// configuration bank at 12'h800 + index
`define PPD_CFG_BASE 12'h800
`define PPD_CX_ACT 8'h30
`define PPD_CX_BHI 8'h60
`define PPD_CX_BLO 8'h61
`define PPD_CX_IRQ 8'h70
`define PPD_CX_ITYP 8'h71
`define PPD_CX_DMA 8'h74
`define PPD_CX_DMA2 8'h75
`define PPD_CX_SETUP 8'hF0
// second level offsets
`define PPD_SL_C0 3'h0
`define PPD_SL_C2 3'h2
`define PPD_SL_C4 3'h4
`define PPD_SL_S0 3'h5
// reset values
`define PPD_RST_ACT 8'h00
`define PPD_RST_BHI 8'h02
`define PPD_RST_BLO 8'h78
`define PPD_RST_IRQ 8'h07
`define PPD_RST_ITYP 8'h02
`define PPD_RST_DMA 8'h04
`define PPD_VAL_DMA2 8'h04
`define PPD_RST_SETUP 8'hF2
`define PPD_RST_EMC 8'h00
// field positions
`define PPD_SETUP_XEN 4
`define PPD_ITYP_WR 1
`define PPD_EMC_MODE_HI 7
`define PPD_EMC_MODE_LO 5
`define PPD_BHI_MASK 8'h07
`define PPD_BLO_MASK 8'hFC
`define PPD_SLOT_BITS 3
`endif

/* File: rtl/ppd_pkg.sv */
// types for the parallel port register decode block
package ppd_pkg;
  // ecp modes from the extended mode control field
  typedef enum logic [2:0] {
    PPD_M_SPP = 3'h0,
    PPD_M_PS2 = 3'h1,
    PPD_M_PPQ = 3'h2,
    PPD_M_ECP = 3'h3,
    PPD_M_EPP = 3'h4,
    PPD_M_RSV = 3'h5,
    PPD_M_TST = 3'h6,
    PPD_M_CFG = 3'h7
  } ppd_mode_type;
  // bus answer state, gray along idle->ans->done
  typedef enum logic [1:0] {
    PPD_S_IDLE = 2'b00,
    PPD_S_ANS = 2'b01,
    PPD_S_DONE = 2'b11
  } ppd_state_type;
endpackage

/* File: rtl/ppd_slot_mem.sv */
// small register file holding the second level extended registers
`timescale 1ns/10ps
`include "ppd_cfg.svh"
module ppd_slot_mem (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic we_i,
  input wire logic [2:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [2:0] raddr_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem_q [0:7];
  logic [7:0] rdata_q;
  // storage, cleared at reset
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_slot
      always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
          mem_q[g] <= 8'h00;
        end else if (we_i && waddr_i == 3'(g)) begin
          mem_q[g] <= wdata_i;
        end
      end
    end
  endgenerate
  // registered read port
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= mem_q[raddr_i];
    end
  end
  assign rdata_o = rdata_q;
endmodule // ppd_slot_mem

/* File: tb/ppd_decode_properties.sv */
// port checker for the parallel port register decode block
`timescale 1ns/10ps
module ppd_decode_properties (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic global_enable_i,
  input wire logic port_active_o,
  input wire logic io_hit_o,
  input wire logic reg_wr_o,
  input wire logic reg_rd_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////////
  // bus answer timing and upper read bits
  property p_ans;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |-> ##[1:3] !avs_waitrequest_o;
  endproperty
  a_ans: assert property (p_ans) else $error("no answer in time");
  property p_one;
    $fell(avs_waitrequest_o) |=> avs_waitrequest_o;
  endproperty
  a_one: assert property (p_one) else $error("answer held too long");
  property p_cause;
    !avs_waitrequest_o |-> $past(avs_read_i || avs_write_i);
  endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_hi0;
    avs_readdata_o[31:8] == 24'h000000;
  endproperty
  a_hi0: assert property (p_hi0) else $error("upper read bits set");
  ////////////////////////////////////////////////////////////////
  // strobes, activity and address match
  property p_wpulse;
    reg_wr_o |=> !reg_wr_o;
  endproperty
  a_wpulse: assert property (p_wpulse) else $error("write strobe too long");
  property p_wsrc;
    reg_wr_o |-> $past(avs_write_i, 1) && !reg_rd_o;
  endproperty
  a_wsrc: assert property (p_wsrc) else $error("stray write strobe");
  property p_rsrc;
    reg_rd_o |-> $past(avs_read_i) && !reg_wr_o;
  endproperty
  a_rsrc: assert property (p_rsrc) else $error("stray read strobe");
  property p_act;
    port_active_o |-> $past(global_enable_i);
  endproperty
  a_act: assert property (p_act) else $error("active without enable");
  property p_hit;
    io_hit_o |-> port_active_o || $past(port_active_o);
  endproperty
  a_hit: assert property (p_hit) else $error("match while inactive");
endmodule // ppd_decode_properties
bind ppd_decode ppd_decode_properties u_props (
  .ref_clk_i(ref_clk_i),
  .reset_n_i(reset_n_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o),
  .global_enable_i(global_enable_i),
  .port_active_o(port_active_o),
  .io_hit_o(io_hit_o),
  .reg_wr_o(reg_wr_o),
  .reg_rd_o(reg_rd_o)
);

/* File: tb/tb_ppd_decode.sv */
// self-checking bench for the parallel port register decode block
`timescale 1ns/10ps
module tb_ppd_decode;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, gen = 0, act, hit, wt, rwr, rrd;
  logic [11:0] addr = 12'h000;
  logic [31:0] wd = 32'h0, rdata;
  logic [15:0] ioa = 16'h0000;
  logic [7:0] pst = 8'h00, qrd = 8'h00, rwd, d;
  logic [7:0] sv [8];
  logic [2:0] mode;
  logic [4:0] sel;
  logic [7:0] ri [8] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'h71, 8'h74, 8'h75, 8'hF0};
  logic [7:0] rv [8] = '{8'h00, 8'h02, 8'h78, 8'h07, 8'h02, 8'h04, 8'h04, 8'hF2};
  int bad_count = 0, checked = 0;
  int nwr = 0, n0 = 0;
  // count write strobes handed to the port engine
  always @(posedge clk) begin
    if (rwr === 1'b1) nwr++;
  end
  ppd_decode dut (.ref_clk_i(clk), .reset_n_i(rst_n), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'h1),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wt), .global_enable_i(gen),
    .io_addr_i(ioa), .port_status_i(pst), .queue_rdata_i(qrd), .mode_o(mode),
    .port_active_o(act), .io_hit_o(hit), .reg_sel_o(sel), .reg_wr_o(rwr),
    .reg_rd_o(rrd), .reg_wdata_o(rwd));
  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  // helpers
  task automatic give_verdict();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  // one avalon cycle; holds the request until waitrequest is seen low
  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] v,
                     output logic [31:0] q);
    int n;
    n = 0;
    addr <= a;
    wd <= {24'h000000, v};
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'b0 && n < 30);
    if (wt !== 1'b0) begin
      bad_count++;
      give_verdict();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wreg(input logic [11:0] a, input logic [7:0] v);
    logic [31:0] q;
    bus(1'b1, a, v, q);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, {24'h000000, e});
  endtask
  function automatic logic [11:0] cx(input logic [7:0] i);
    return {4'h8, i};
  endfunction
  // mode 4 needs setup mode field 111, otherwise it falls back to 1
  function automatic logic [2:0] eff(input logic [7:0] s, input logic [2:0] m);
    return (m == 3'h4 && s[7:5] != 3'h7) ? 3'h1 : m;
  endfunction
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(77));
    pst <= 8'($urandom);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) rchk(cx(ri[i]), rv[i]);
    wreg(cx(8'h60), 8'hFB);
    rchk(cx(8'h60), 8'h03);
    wreg(cx(8'h61), 8'hFB);
    rchk(cx(8'h61), 8'hF8);
    wreg(cx(8'h60), 8'h02);
    wreg(cx(8'h61), 8'h78);
    wreg(cx(8'h71), 8'h00);
    rchk(cx(8'h71), 8'h00);
    wreg(cx(8'h71), 8'hFF);
    rchk(cx(8'h71), 8'h02);
    wreg(cx(8'h75), 8'h00);
    rchk(cx(8'h75), 8'h04);
    for (int i = 0; i < 4; i++) begin
      d = 8'($urandom);
      wreg(cx(8'h70), d);
      rchk(cx(8'h70), d);
      wreg(cx(8'h74), ~d);
      rchk(cx(8'h74), ~d);
    end
    // activation and base address match, 8-byte compare while extended on
    gen <= 1'b1;
    wreg(cx(8'h30), 8'h01);
    rchk(cx(8'h30), 8'h01);
    chk(act, 1'b1);
    ioa <= 16'h027C;
    repeat (2) @(posedge clk);
    chk(hit, 1'b1);
    wreg(cx(8'hF0), 8'hE2);
    repeat (2) @(posedge clk);
    chk(hit, 1'b0);
    gen <= 1'b0;
    repeat (2) @(posedge clk);
    chk(act, 1'b0);
    gen <= 1'b1;
    // extended trio refused while access bit clear
    rchk(12'h403, 8'h00);
    wreg(cx(8'hF0), 8'hF2);
    for (int i = 0; i < 8; i++) begin
      if (i inside {0, 2, 4, 5}) begin
        sv[i] = 8'($urandom);
        wreg(12'h403, i[7:0]);
        wreg(12'h404, sv[i]);
      end
    end
    for (int i = 0; i < 8; i++) begin
      if (i inside {0, 2, 4, 5}) begin
        wreg(12'h403, i[7:0]);
        rchk(12'h404, sv[i]);
      end
    end
    wreg(cx(8'hF0), 8'hE2);
    wreg(12'h403, 8'h02);
    wreg(cx(8'hF0), 8'hF2);
    rchk(12'h403, 8'h05);
    // every mode through the extended mode control
    for (int m = 0; m < 8; m++) begin
      wreg(12'h402, {m[2:0], 5'h00});
      @(posedge clk);
      chk(mode, eff(8'hF2, m[2:0]));
      rchk(cx(8'h71), {7'h01, m == 7});
      if (m == 0) rchk(12'h001, pst);
      if (m == 7) rchk(12'h400, 8'h10);
      d = 8'($urandom);
      n0 = nwr;
      wreg(12'h000, d);
      chk(rwd, d);
      chk(sel != 5'h00, m inside {0, 1, 3, 4});
      chk(nwr - n0, m inside {0, 1, 3, 4});
    end
    wreg(cx(8'hF0), 8'h12);
    wreg(12'h402, 8'h80);
    @(posedge clk);
    chk(mode, eff(8'h12, 3'h4));
    rchk(12'h7FF, 8'h00);
    rchk(cx(8'h20), 8'h00);
    give_verdict();
  end
endmodule // tb_ppd_decode
